// *** rtl/fxr_cfg.svh ***
// register map, reset values and fixed constants of the fsk receive back end
`ifndef FXR_CFG_SVH
`define FXR_CFG_SVH
`define FXR_OFS_CTRL      12'h000
`define FXR_OFS_RAWLEN    12'h004
`define FXR_OFS_SYNCW     12'h008
`define FXR_OFS_LPLTIME   12'h00c
`define FXR_OFS_STATUS    12'h010
`define FXR_CTRL_RST      32'h0000_1028
`define FXR_RAWLEN_RST    32'h0000_0000
`define FXR_SYNCW_RST     32'h0000_0000
`define FXR_LPLTIME_RST   32'h0010_0010
`define FXR_CTRL_MSE      0
`define FXR_CTRL_SS       1
`define FXR_CTRL_HARD     2
`define FXR_CTRL_RBREV    3
`define FXR_CTRL_OVR      4
`define FXR_CTRL_LPL      6
`define FXR_CTRL_RSSIPD   7
`define FXR_CTRL_PTO      8
`define FXR_CTRL_SFDT     9
`define FXR_CTRL_RAW0     13
`define FXR_CTRL_FEC0     14
`define FXR_CTRL_RAW1     15
`define FXR_CTRL_FEC1     16
`define FXR_CTRL_FCSF     17
`define FXR_CTRL_ADRF     18
`define FXR_OVR_OFF       2'h3
`define FXR_OVR_STEP_DB   6'h06
`define FXR_PN9_SEED      9'h1ff
`define FXR_SOFT_MAX      4'h7
`define FXR_SOFT_MIN      4'h9
`define FXR_TSFD_MULT     9'h007
`define FXR_PHR_BITS      5'h10
`endif

// *** rtl/fxr_pkg.sv ***
// types shared by the fsk receive back end
package fxr_pkg;
  typedef enum logic [2:0] {
    ST_LISTEN,
    ST_LOCK,
    ST_PHR,
    ST_MSWR,
    ST_PAYLOAD
  } fxr_state_t;
endpackage : fxr_pkg

// *** rtl/fxr_rx_backend.sv ***
// fsk receive back end: sfd correlator, header parsing, raw capture, override and low-power listen
`timescale 1ns/1ps
`include "fxr_cfg.svh"
module fxr_rx_backend (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [11:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              sym_valid,
  input  wire logic [3:0]        sym_soft,
  input  wire logic              dec_valid,
  input  wire logic              dec_bit,
  input  wire logic              preamble_found,
  input  wire logic [5:0]        strength_rise_db,
  input  wire logic [7:0]        rssi_dbm,
  output logic                   fb_wr,
  output logic      [7:0]        fb_data,
  output logic                   frame_start_irq,
  output logic                   frame_end,
  output logic                   front_end_on,
  output logic                   preamble_locked,
  output logic                   fcs_check_en,
  output logic                   addr_filter_en,
  output logic                   dewhiten_active
);
  logic [31:0]        ctrl_q, ctrl_d, rawlen_q, rawlen_d, syncw_q, syncw_d, lpl_q, lpl_d;
  logic [31:0]        rdata_q, rdata_d, status;
  logic               wr_pend_q, wr_pend_d;
  logic [11:0]        wr_addr_q, wr_addr_d;
  fxr_pkg::fxr_state_t state_q, state_d;
  logic [127:0]       hist_q, hist_d;
  logic [15:0]        phr_q, phr_d, phr_full;
  logic [4:0]         bcnt_q, bcnt_d;
  logic [7:0]         oct_q, oct_d;
  logic [8:0]         pn9_q, pn9_d;
  logic [10:0]        left_q, left_d, rxlen_q, rxlen_d, hdr_len;
  logic               raw_q, raw_d, fec_q, fec_d, dw_q, dw_d, ms_q, ms_d;
  logic               rb1_q, rb1_d, rb2_q, rb2_d, fcst_q, fcst_d, sfd_q, sfd_d;
  logic [7:0]         ed_q, ed_d, fbd_q, fbd_d;
  logic               fbw_q, fbw_d, irq_q, irq_d, fend_q, fend_d;
  logic               lpoff_q, lpoff_d;
  logic [15:0]        lpcnt_q, lpcnt_d;
  logic signed [8:0]  c0_new, c1_new, c0_old, tsfd;
  logic               h0, h1, hs, sync_hit, ovr_hit, in_v, in_b, wbit, addr_ok;
  logic [3:0]         q_in;
  logic [5:0]         ovr_db;

  // signed sum of 16 soft values, each taken with the sign of its word bit
  function automatic logic signed [8:0] corr16(input logic [63:0] win, input logic [15:0] w);
    logic signed [8:0] acc;
    logic signed [3:0] x;
    acc = 9'sh000;
    for (int i = 0; i < 16; i++)
    begin
      x = signed'(win[4*i +: 4]);
      acc = w[i] ? acc + 9'(x) : acc - 9'(x);
    end
    return acc;
  endfunction : corr16

  function automatic logic [7:0] rev8(input logic [7:0] v);
    return {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
  endfunction : rev8

  // first received bit lands in bit 0 when lsb_first, else in bit 7
  function automatic logic [7:0] place_bit(input logic [7:0] o, input logic [2:0] idx, input logic b,
                                           input logic lsb_first);
    logic [7:0] r;
    r = o;
    if (lsb_first)
      r[idx] = b;
    else
      r[3'h7 - idx] = b;
    return r;
  endfunction : place_bit

  // bus slave: zero wait states, reads answered from a flop loaded in the address phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;
  assign addr_ok   = hsel && htrans[1] && hready;
  assign status    = {ed_q, 5'h00, state_q == fxr_pkg::ST_PAYLOAD, state_q == fxr_pkg::ST_LOCK,
                      sfd_q, dw_q, fcst_q, rb2_q, rb1_q, ms_q, rxlen_q};

  always_comb
  begin
    ctrl_d    = ctrl_q;
    rawlen_d  = rawlen_q;
    syncw_d   = syncw_q;
    lpl_d     = lpl_q;
    wr_pend_d = addr_ok && hwrite;
    wr_addr_d = addr_ok ? haddr : wr_addr_q;
    rdata_d   = rdata_q;
    if (wr_pend_q)
    begin
      if (wr_addr_q == `FXR_OFS_CTRL)
        ctrl_d = {13'h0000, hwdata[18:0]};
      else if (wr_addr_q == `FXR_OFS_RAWLEN)
        rawlen_d = {21'h000000, hwdata[10:0]};
      else if (wr_addr_q == `FXR_OFS_SYNCW)
        syncw_d = hwdata;
      else if (wr_addr_q == `FXR_OFS_LPLTIME)
        lpl_d = hwdata;
    end
    if (addr_ok && !hwrite)
    begin
      if (haddr == `FXR_OFS_CTRL)
        rdata_d = ctrl_q;
      else if (haddr == `FXR_OFS_RAWLEN)
        rdata_d = rawlen_q;
      else if (haddr == `FXR_OFS_SYNCW)
        rdata_d = syncw_q;
      else if (haddr == `FXR_OFS_LPLTIME)
        rdata_d = lpl_q;
      else if (haddr == `FXR_OFS_STATUS)
        rdata_d = status;
      else
        rdata_d = 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q    <= `FXR_CTRL_RST;
      rawlen_q  <= `FXR_RAWLEN_RST;
      syncw_q   <= `FXR_SYNCW_RST;
      lpl_q     <= `FXR_LPLTIME_RST;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      rdata_q   <= 32'h0000_0000;
    end
    else
    begin
      ctrl_q    <= ctrl_d;
      rawlen_q  <= rawlen_d;
      syncw_q   <= syncw_d;
      lpl_q     <= lpl_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q   <= rdata_d;
    end
  end

  // correlation on the stored history; entry 0 holds the newest symbol
  assign tsfd    = 9'(`FXR_TSFD_MULT * {5'h00, ctrl_q[`FXR_CTRL_SFDT +: 4]});
  assign c0_new  = corr16(hist_q[63:0], syncw_q[15:0]);
  assign c1_new  = corr16(hist_q[63:0], syncw_q[31:16]);
  assign c0_old  = corr16(hist_q[127:64], syncw_q[15:0]);
  assign h0      = c0_new > tsfd;
  assign h1      = c1_new > tsfd;
  assign hs      = (c0_old > tsfd) && h1;
  assign sync_hit = ctrl_q[`FXR_CTRL_SS] ? hs : (h0 || h1);
  assign ovr_db  = `FXR_OVR_STEP_DB * {4'h0, ctrl_q[`FXR_CTRL_OVR +: 2]} + `FXR_OVR_STEP_DB;
  assign ovr_hit = (ctrl_q[`FXR_CTRL_OVR +: 2] != `FXR_OVR_OFF) && (strength_rise_db > ovr_db);
  // soft range -7..+7; hard mode keeps only the sign
  assign q_in    = ctrl_q[`FXR_CTRL_HARD] ? (sym_soft[3] ? `FXR_SOFT_MIN : `FXR_SOFT_MAX) : sym_soft;
  // coded frames take information bits from the decoder, uncoded ones the symbol sign
  assign in_v    = fec_q ? dec_valid : sym_valid;
  assign in_b    = fec_q ? dec_bit : ~sym_soft[3];
  assign wbit    = in_b ^ (dw_q & pn9_q[0]);
  // shift right so that the first header bit ends up in bit 0 after sixteen bits
  assign phr_full = {in_b, phr_q[15:1]};
  always_comb
  begin
    for (int j = 0; j < 11; j++)
      hdr_len[10 - j] = phr_full[5 + j];
  end

  assign fb_wr           = fbw_q;
  assign fb_data         = fbd_q;
  assign frame_start_irq = irq_q;
  assign frame_end       = fend_q;
  assign preamble_locked = state_q != fxr_pkg::ST_LISTEN;
  assign front_end_on    = !(ctrl_q[`FXR_CTRL_LPL] && lpoff_q && state_q == fxr_pkg::ST_LISTEN);
  assign fcs_check_en    = ctrl_q[`FXR_CTRL_FCSF] && !raw_q && !ms_q;
  assign addr_filter_en  = ctrl_q[`FXR_CTRL_ADRF] && !raw_q && !ms_q;
  assign dewhiten_active = dw_q && !raw_q;

  always_comb
  begin
    state_d = state_q;
    hist_d  = hist_q;
    phr_d   = phr_q;
    bcnt_d  = bcnt_q;
    oct_d   = oct_q;
    pn9_d   = pn9_q;
    left_d  = left_q;
    rxlen_d = rxlen_q;
    raw_d   = raw_q;
    fec_d   = fec_q;
    dw_d    = dw_q;
    ms_d    = ms_q;
    rb1_d   = rb1_q;
    rb2_d   = rb2_q;
    fcst_d  = fcst_q;
    sfd_d   = sfd_q;
    ed_d    = ed_q;
    fbd_d   = fbd_q;
    fbw_d   = 1'b0;
    irq_d   = 1'b0;
    fend_d  = 1'b0;
    lpoff_d = lpoff_q;
    lpcnt_d = lpcnt_q;
    case (state_q)
      fxr_pkg::ST_LISTEN:
      begin
        // duty cycle runs only while listening; lock parks it in the on phase
        if (ctrl_q[`FXR_CTRL_LPL])
        begin
          if (lpcnt_q >= (lpoff_q ? lpl_q[31:16] : lpl_q[15:0]))
          begin
            lpcnt_d = 16'h0000;
            lpoff_d = !lpoff_q;
          end
          else
            lpcnt_d = lpcnt_q + 16'h0001;
        end
        else
        begin
          lpoff_d = 1'b0;
          lpcnt_d = 16'h0000;
        end
        if (preamble_found && front_end_on)
        begin
          state_d = fxr_pkg::ST_LOCK;
          hist_d  = '0;
          lpoff_d = 1'b0;
          lpcnt_d = 16'h0000;
        end
      end
      fxr_pkg::ST_LOCK:
      begin
        if (ovr_hit || !preamble_found)
          state_d = fxr_pkg::ST_LISTEN;
        else if (sync_hit)
        begin
          // word 0 wins when both hypotheses hold; single sense always reports word 0
          sfd_d  = !ctrl_q[`FXR_CTRL_SS] && !h0;
          raw_d  = sfd_d ? ctrl_q[`FXR_CTRL_RAW1] : ctrl_q[`FXR_CTRL_RAW0];
          fec_d  = sfd_d ? ctrl_q[`FXR_CTRL_FEC1] : ctrl_q[`FXR_CTRL_FEC0];
          ed_d   = rssi_dbm;
          ms_d   = 1'b0;
          dw_d   = 1'b0;
          bcnt_d = 5'h00;
          oct_d  = 8'h00;
          if (raw_d)
          begin
            // length comes from software because there is no header
            left_d  = rawlen_q[10:0];
            rxlen_d = rawlen_q[10:0];
            irq_d   = 1'b1;
            state_d = fxr_pkg::ST_PAYLOAD;
          end
          else
            state_d = fxr_pkg::ST_PHR;
        end
        else if (sym_valid)
          hist_d = {hist_q[123:0], q_in};
      end
      fxr_pkg::ST_PHR:
      begin
        if (in_v)
        begin
          phr_d  = phr_full;
          bcnt_d = bcnt_q + 5'h01;
          if (bcnt_q == `FXR_PHR_BITS - 5'h01)
          begin
            bcnt_d = 5'h00;
            if (phr_full[0] && ctrl_q[`FXR_CTRL_MSE])
            begin
              ms_d    = 1'b1;
              fbd_d   = ctrl_q[`FXR_CTRL_RBREV] ? phr_full[7:0] : rev8(phr_full[7:0]);
              fbw_d   = 1'b1;
              irq_d   = 1'b1;
              state_d = fxr_pkg::ST_MSWR;
            end
            else if (hdr_len == 11'h000)
              state_d = fxr_pkg::ST_LISTEN;
            else
            begin
              rb1_d   = phr_full[1];
              rb2_d   = phr_full[2];
              fcst_d  = phr_full[3];
              dw_d    = phr_full[4];
              rxlen_d = hdr_len;
              left_d  = hdr_len;
              pn9_d   = `FXR_PN9_SEED;
              irq_d   = 1'b1;
              state_d = fxr_pkg::ST_PAYLOAD;
            end
          end
        end
      end
      fxr_pkg::ST_MSWR:
      begin
        fbd_d   = ctrl_q[`FXR_CTRL_RBREV] ? phr_q[15:8] : rev8(phr_q[15:8]);
        fbw_d   = 1'b1;
        fend_d  = 1'b1;
        state_d = fxr_pkg::ST_LISTEN;
      end
      fxr_pkg::ST_PAYLOAD:
      begin
        if (in_v)
        begin
          // header mode fills octets lsb first; raw mode follows the bit-reverse setting
          oct_d  = place_bit(oct_q, bcnt_q[2:0], wbit, !raw_q || ctrl_q[`FXR_CTRL_RBREV]);
          pn9_d  = {pn9_q[0] ^ pn9_q[5], pn9_q[8:1]};
          bcnt_d = {2'b00, bcnt_q[2:0] + 3'h1};
          if (bcnt_q[2:0] == 3'h7)
          begin
            fbd_d  = oct_d;
            fbw_d  = 1'b1;
            left_d = left_q - 11'h001;
            if (left_q <= 11'h001)
            begin
              fend_d  = 1'b1;
              state_d = fxr_pkg::ST_LISTEN;
            end
          end
        end
      end
      default:
        state_d = fxr_pkg::ST_LISTEN;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= fxr_pkg::ST_LISTEN;
      hist_q  <= '0;
      phr_q   <= 16'h0000;
      bcnt_q  <= 5'h00;
      oct_q   <= 8'h00;
      pn9_q   <= `FXR_PN9_SEED;
      left_q  <= 11'h000;
      rxlen_q <= 11'h000;
      raw_q   <= 1'b0;
      fec_q   <= 1'b0;
      dw_q    <= 1'b0;
      ms_q    <= 1'b0;
      rb1_q   <= 1'b0;
      rb2_q   <= 1'b0;
      fcst_q  <= 1'b0;
      sfd_q   <= 1'b0;
      ed_q    <= 8'h00;
      fbd_q   <= 8'h00;
      fbw_q   <= 1'b0;
      irq_q   <= 1'b0;
      fend_q  <= 1'b0;
      lpoff_q <= 1'b0;
      lpcnt_q <= 16'h0000;
    end
    else
    begin
      state_q <= state_d;
      hist_q  <= hist_d;
      phr_q   <= phr_d;
      bcnt_q  <= bcnt_d;
      oct_q   <= oct_d;
      pn9_q   <= pn9_d;
      left_q  <= left_d;
      rxlen_q <= rxlen_d;
      raw_q   <= raw_d;
      fec_q   <= fec_d;
      dw_q    <= dw_d;
      ms_q    <= ms_d;
      rb1_q   <= rb1_d;
      rb2_q   <= rb2_d;
      fcst_q  <= fcst_d;
      sfd_q   <= sfd_d;
      ed_q    <= ed_d;
      fbd_q   <= fbd_d;
      fbw_q   <= fbw_d;
      irq_q   <= irq_d;
      fend_q  <= fend_d;
      lpoff_q <= lpoff_d;
      lpcnt_q <= lpcnt_d;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_hdr_done;
    state_q == fxr_pkg::ST_PHR && in_v && bcnt_q == `FXR_PHR_BITS - 5'h01;
  endsequence
  sequence s_ms_hdr;
    s_hdr_done ##0 phr_full[0] && ctrl_q[`FXR_CTRL_MSE];
  endsequence

  chk_zero_len_drop: assert property (s_hdr_done ##0 !(phr_full[0] && ctrl_q[`FXR_CTRL_MSE]) && hdr_len == 11'h000
    |=> !frame_start_irq && state_q == fxr_pkg::ST_LISTEN) else $error("zero length frame not dropped");
  chk_ms_two_writes: assert property (s_ms_hdr |=> ms_q && fb_wr && frame_start_irq ##1 fb_wr && frame_end)
    else $error("mode switch header not written as two octets");
  chk_ms_no_filter: assert property (ms_q |-> !fcs_check_en && !addr_filter_en)
    else $error("filtering active on mode switch frame");
  chk_raw_no_filter: assert property (raw_q |-> !fcs_check_en && !addr_filter_en && !dewhiten_active)
    else $error("raw frame uses de-whitening or filtering");
  chk_override_exit: assert property (state_q == fxr_pkg::ST_LOCK && ovr_hit |=> state_q == fxr_pkg::ST_LISTEN)
    else $error("override did not return to listen");
  chk_off_only_listen: assert property (!front_end_on |-> state_q == fxr_pkg::ST_LISTEN && ctrl_q[`FXR_CTRL_LPL])
    else $error("front end off outside low-power listen");
  chk_lock_needs_on: assert property (state_q == fxr_pkg::ST_LISTEN && !front_end_on
    |=> state_q == fxr_pkg::ST_LISTEN) else $error("preamble accepted during off phase");
  chk_hard_quant: assert property (ctrl_q[`FXR_CTRL_HARD] && state_q == fxr_pkg::ST_LOCK && sym_valid && !sync_hit
    && !ovr_hit && preamble_found |=> hist_q[3:0] == ($past(sym_soft[3]) ? `FXR_SOFT_MIN : `FXR_SOFT_MAX))
    else $error("hard decision value wrong");
  chk_dual_pick: assert property (state_q == fxr_pkg::ST_LOCK && preamble_found && !ovr_hit && !ctrl_q[`FXR_CTRL_SS]
    && h1 |=> state_q != fxr_pkg::ST_LOCK && sfd_q == !$past(h0)) else $error("dual sense decision wrong");
  chk_len_report: assert property (s_hdr_done ##0 !(phr_full[0] && ctrl_q[`FXR_CTRL_MSE]) && hdr_len != 11'h000
    |=> frame_start_irq && rxlen_q == $past(hdr_len)) else $error("length not reported");
endmodule : fxr_rx_backend

// *** sim/fxr_tx_model.sv ***
// remote fsk transmitter model: preamble flag, sync words and data symbols
`timescale 1ns/1ps
module fxr_tx_model (
  input  wire logic       hclk,
  output logic            sym_valid,
  output logic [3:0]      sym_soft,
  output logic            preamble_found,
  output logic [5:0]      strength_rise_db,
  output logic [7:0]      rssi_dbm,
  output logic            dec_valid,
  output logic            dec_bit
);
  initial
  begin
    sym_valid = 1'b0;
    sym_soft = 4'h0;
    preamble_found = 1'b0;
    strength_rise_db = 6'h00;
    rssi_dbm = 8'hc4;
    dec_valid = 1'b0;
    dec_bit = 1'b0;
  end
  // between pulses the line shows the inverse of the last symbol, never a stale copy
  task automatic sym(input logic [3:0] v);
    @(posedge hclk);
    sym_valid <= 1'b1;
    sym_soft <= v;
    @(posedge hclk);
    sym_valid <= 1'b0;
    sym_soft <= ~v;
  endtask : sym
  task automatic bits(input logic [31:0] v, input int n, input logic lsb);
    for (int i = 0; i < n; i++)
      sym((lsb ? v[i] : v[n-1-i]) ? 4'h7 : 4'h9);
  endtask : bits
  // decoder output for coded frames, first bit first
  task automatic dbits(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge hclk);
      dec_valid <= 1'b1;
      dec_bit <= v[i];
      @(posedge hclk);
      dec_valid <= 1'b0;
      dec_bit <= ~v[i];
    end
  endtask : dbits
  task automatic env(input logic pf, input logic [5:0] rise);
    @(posedge hclk);
    preamble_found <= pf;
    strength_rise_db <= rise;
  endtask : env
  // flush symbols keep every partially filled window short of a full match
  task automatic sync(input logic [31:0] w, input int n, input logic [3:0] mag, input logic [3:0] fl);
    env(1'b1, 6'h00);
    repeat (16) sym(fl);
    for (int i = n - 1; i >= 0; i--)
      sym(w[i] ? mag : 4'h0 - mag);
    @(posedge hclk);
    preamble_found <= 1'b0;
  endtask : sync
endmodule : fxr_tx_model

// *** sim/tb_top.sv ***
// self-checking bench: register access over the bus and received frames
`timescale 1ns/1ps
module tb_top;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        sym_valid;
  logic [3:0]  sym_soft;
  logic        pf;
  logic [5:0]  rise;
  logic [7:0]  rssi;
  logic        fb_wr;
  logic [7:0]  fb_data;
  logic        frame_start_irq;
  logic        front_end_on;
  logic        preamble_locked;
  logic        fcs_check_en;
  logic        addr_filter_en;
  logic        dewhiten_active;
  logic        dv;
  logic        db;
  logic        fend;
  logic [31:0] rd;
  logic [7:0]  octs[$];
  int          err_count;
  int          n_checks;
  int          irqs;
  int          ends;
  int          cyc;
  int          c;
  fxr_rx_backend i_fxr_rx_backend (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sym_valid(sym_valid), .sym_soft(sym_soft), .dec_valid(dv), .dec_bit(db),
    .preamble_found(pf), .strength_rise_db(rise), .rssi_dbm(rssi), .fb_wr(fb_wr), .fb_data(fb_data),
    .frame_start_irq(frame_start_irq), .frame_end(fend), .front_end_on(front_end_on),
    .preamble_locked(preamble_locked), .fcs_check_en(fcs_check_en), .addr_filter_en(addr_filter_en),
    .dewhiten_active(dewhiten_active));
  fxr_tx_model i_tx (.hclk(hclk), .sym_valid(sym_valid), .sym_soft(sym_soft), .preamble_found(pf),
    .strength_rise_db(rise), .rssi_dbm(rssi), .dec_valid(dv), .dec_bit(db));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  // one single transfer: address phase held until hready, then data phase until hready
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic cnt_low(input logic fe, input int n, output int k);
    k = 0;
    repeat (n)
    begin
      @(posedge hclk);
      if ((fe ? front_end_on : preamble_locked) !== 1'b1)
        k++;
    end
  endtask : cnt_low
  task automatic status();
    repeat (4) @(posedge hclk);
    bus(1'b0, 12'h010, 32'h0, rd);
  endtask : status
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    cyc++;
    if (fb_wr === 1'b1)
      octs.push_back(fb_data);
    if (frame_start_irq === 1'b1)
      irqs++;
    if (fend === 1'b1)
      ends++;
    if (cyc == 20000)
    begin
      err_count++;
      end_of_test();
    end
  end
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 12'h000, 32'h0, rd);
    chk(rd, 32'h0000_1028);
    bus(1'b0, 12'h00c, 32'h0, rd);
    chk(rd, 32'h0010_0010);
    bus(1'b0, 12'h020, 32'h0, rd);
    chk(rd, 32'h0);
    chk(32'({hresp, hreadyout}), 32'h1);
    $display("test reset values done");
    // detection off, so a set first header bit still means a normal frame
    bus(1'b1, 12'h008, 32'hcc33_f0f0, rd);
    bus(1'b1, 12'h000, 32'h0006_1eac, rd);
    i_tx.sync(32'hf0f0, 16, 4'h2, 4'hf);
    i_tx.bits(32'h400b, 16, 1'b1);
    i_tx.bits(32'h3ca5, 16, 1'b1);
    status();
    chk(rd, 32'hc400_5002);
    chk(32'(octs.size()), 32'h2);
    chk(32'(octs[0]), 32'ha5);
    chk(32'(octs[1]), 32'h3c);
    chk(32'(irqs), 32'h1);
    chk(32'(fcs_check_en), 32'h1);
    octs.delete();
    i_tx.sync(32'hf0f0, 16, 4'h2, 4'hf);
    i_tx.bits(32'h0, 16, 1'b1);
    status();
    chk(32'(irqs), 32'h1);
    chk(32'(octs.size()), 32'h0);
    chk(32'(preamble_locked), 32'h0);
    // whitened frame of one octet: the first eight sequence bits are all ones
    i_tx.sync(32'hf0f0, 16, 4'h2, 4'hf);
    i_tx.bits(32'h8010, 16, 1'b1);
    i_tx.bits(32'h5a, 8, 1'b1);
    status();
    chk(rd, 32'hc400_8001);
    chk(32'(octs[0]), 32'ha5);
    chk(32'(dewhiten_active), 32'h1);
    octs.delete();
    $display("test header frames done");
    // reserved, fcs type and whitening status are not meaningful here and stay unchecked
    bus(1'b1, 12'h000, 32'h0006_1e29, rd);
    i_tx.sync(32'hf0f0, 16, 4'h7, 4'h0);
    i_tx.bits(32'h5a81, 16, 1'b1);
    status();
    chk(32'(rd[11]), 32'h1);
    chk(32'(octs[0]), 32'h81);
    chk(32'(octs[1]), 32'h5a);
    chk(32'(irqs), 32'h3);
    chk(32'({fcs_check_en, addr_filter_en}), 32'h0);
    octs.delete();
    bus(1'b1, 12'h004, 32'h1, rd);
    bus(1'b1, 12'h000, 32'h0006_9e20, rd);
    i_tx.sync(32'hcc33, 16, 4'h7, 4'h0);
    i_tx.bits(32'hb4, 8, 1'b0);
    status();
    chk(32'(rd[16]), 32'h1);
    chk(32'(octs[0]), 32'hb4);
    chk(32'(irqs), 32'h4);
    chk(32'({fcs_check_en, dewhiten_active}), 32'h0);
    octs.delete();
    bus(1'b1, 12'h000, 32'h0006_7e28, rd);
    i_tx.sync(32'hf0f0, 16, 4'h7, 4'h0);
    i_tx.dbits(8'h3a);
    status();
    chk(32'(octs[0]), 32'h3a);
    chk(32'(irqs), 32'h5);
    octs.delete();
    bus(1'b1, 12'h000, 32'h0006_1e2a, rd);
    i_tx.sync(32'hf0f0_cc33, 32, 4'h7, 4'h0);
    i_tx.bits(32'h8000, 16, 1'b1);
    i_tx.bits(32'h5c, 8, 1'b1);
    status();
    chk(32'(rd[16]), 32'h0);
    chk(32'(octs[0]), 32'h5c);
    chk(32'(ends), 32'h6);
    $display("test switch raw single done");
    // override: at the threshold, just above it, and disabled
    for (int k = 0; k < 3; k++)
    begin
      bus(1'b1, 12'h000, (k == 2) ? 32'h0006_1e38 : 32'h0006_1e28, rd);
      i_tx.env(1'b1, (k == 0) ? 6'd18 : ((k == 1) ? 6'd19 : 6'd40));
      repeat (3) @(posedge hclk);
      cnt_low(1'b0, 8, c);
      chk(32'(c != 0), (k == 1) ? 32'h1 : 32'h0);
      i_tx.env(1'b0, 6'h00);
      repeat (3) @(posedge hclk);
    end
    bus(1'b1, 12'h00c, 32'h0003_0003, rd);
    bus(1'b1, 12'h000, 32'h0006_1e68, rd);
    cnt_low(1'b1, 20, c);
    chk(32'(c != 0), 32'h1);
    i_tx.env(1'b1, 6'h00);
    repeat (10) @(posedge hclk);
    cnt_low(1'b1, 20, c);
    chk(32'(c), 32'h0);
    chk(32'(preamble_locked), 32'h1);
    i_tx.env(1'b0, 6'h00);
    $display("test override listen done");
    end_of_test();
  end
endmodule : tb_top
